// ===== bench/msi_host.sv
// msi_host: host side of the byte register bus.
// assumes one caller at a time.
`timescale 1ns/1ps
module msi_host
(
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    input wire logic i_rvalid,
    output msi_pkg::msi_reg_req_t o_req
);
    import msi_pkg::*;
    initial o_req = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] m;
        m = (a == 8'hD4) ? 8'h77 : (a == 8'hD5) ? 8'h07 : 8'hFF;
        @(posedge i_clk);
        o_req <= '{1'b1, 1'b0, a, d & m};
        @(posedge i_clk);
        o_req <= '{1'b0, 1'b0, ~a, ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_req <= '{1'b0, 1'b1, a, 8'hA5};
        @(posedge i_clk);
        o_req <= '{1'b0, 1'b0, ~a, 8'h5A};
        @(negedge i_clk);
        d = i_rvalid ? i_rdata : 8'hXX;
    endtask
endmodule

// ===== bench/msi_regs_monitor.sv
// msi_regs_monitor: port timing checks for msi_regs.
// assumes it is bound to msi_regs.
`timescale 1ns/1ps
module msi_regs_monitor
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire msi_pkg::msi_reg_req_t i_req,
    input wire logic o_rvalid,
    input wire logic i_sample_valid,
    input wire msi_pkg::msi_vec3_t o_sample,
    input wire logic o_sample_valid,
    input wire msi_pkg::msi_matrix_t o_softiron
);
    import msi_pkg::*;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);
    AST_RD_ANSWER: assert property (i_req.rd_en |=> o_rvalid)
        else $error("read gave no answer");
    AST_SYM_R1C2: assert property (
        o_softiron.r1c2 == o_softiron.r2c1)
        else $error("row1col2 not shared");
    AST_SYM_R1C3: assert property (
        o_softiron.r1c3 == o_softiron.r3c1)
        else $error("row1col3 not shared");
    AST_SYM_R2C3: assert property (
        o_softiron.r2c3 == o_softiron.r3c2)
        else $error("row2col3 not shared");
    AST_WR_LOW: assert property (
        i_req.wr_en && i_req.addr == 8'hC8 |=>
        o_softiron.r1c2[7:0] == $past(i_req.wdata))
        else $error("low byte write lost");
    AST_WR_HIGH: assert property (
        i_req.wr_en && i_req.addr == 8'hD1 |=>
        o_softiron.r3c3[15:8] == $past(i_req.wdata))
        else $error("high byte write lost");
    AST_SMP_VALID: assert property (i_sample_valid |=> o_sample_valid)
        else $error("sample not passed on");
    AST_SMP_HOLD: assert property (!i_sample_valid |=> $stable(o_sample))
        else $error("sample changed without valid");
    cover property (i_req.rd_en ##1 o_rvalid);
    cover property (i_sample_valid ##1 o_sample_valid);
    cover property (i_req.wr_en && i_req.addr == 8'hD4);
endmodule

bind msi_regs msi_regs_monitor u_mon(.i_clk(i_clk), .i_reset(i_reset),
    .i_req(i_req), .o_rvalid(o_rvalid), .i_sample_valid(i_sample_valid),
    .o_sample(o_sample), .o_sample_valid(o_sample_valid),
    .o_softiron(o_softiron));

// ===== bench/test_mag_softiron_axis_remap_regs.sv
// test_mag_softiron_axis_remap_regs: self-checking bench for msi_regs.
// assumes msi_host on the bus and the bound monitor.
`timescale 1ns/1ps
module test_mag_softiron_axis_remap_regs;
    import msi_pkg::*;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    msi_reg_req_t req;
    logic [7:0] rdata;
    logic rvalid;
    logic svld = 1'b0;
    msi_vec3_t smp = '0;
    logic osv;
    msi_vec3_t osmp;
    msi_matrix_t mtx;
    int error_cnt = 0;
    int checks_done = 0;
    int cycles = 0;
    always #2.5 i_clk = ~i_clk;
    msi_host u_host(.i_clk(i_clk), .i_rdata(rdata), .i_rvalid(rvalid),
        .o_req(req));
    msi_regs u_dut(.i_clk(i_clk), .i_reset(i_reset), .i_req(req),
        .o_rdata(rdata), .o_rvalid(rvalid), .i_sample_valid(svld),
        .i_sample(smp), .o_sample_valid(osv), .o_sample(osmp),
        .o_softiron(mtx));
    task automatic chk(input string n, input logic [143:0] g,
        input logic [143:0] e);
        checks_done++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[ERR] %s expected %0h seen %0h", n, e, g);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        u_host.rd(a, d);
        chk("rdata", d, e);
    endtask
    function automatic logic [15:0] pick(input logic [2:0] s,
        input msi_vec3_t v);
        case (s)
            3'h1: return -v.y;
            3'h2: return v.x;
            3'h3: return -v.x;
            3'h4: return -v.z;
            3'h5: return v.z;
            default: return v.y;
        endcase
    endfunction
    task automatic send(input msi_vec3_t v);
        @(posedge i_clk);
        smp <= v;
        svld <= 1'b1;
        @(posedge i_clk);
        svld <= 1'b0;
        smp <= ~v;
        @(negedge i_clk);
        chk("valid", osv, 1'b1);
    endtask
    task automatic t_reset();
        for (int i = 0; i < 12; i++)
            rdchk(8'hC6 + 8'(i), (i == 1 || i == 7 || i == 11) ? 8'h3C :
                8'h00);
        rdchk(8'hD4, 8'h05);
        rdchk(8'hD5, 8'h02);
        chk("matrix", mtx, {16'h3C00, 48'h0, 16'h3C00, 48'h0,
            16'h3C00});
    endtask
    task automatic t_coef();
        logic [15:0] c [6];
        for (int i = 0; i < 12; i++)
            u_host.wr(8'hC6 + 8'(i), 8'h90 + 8'(i));
        for (int k = 0; k < 6; k++)
            c[k] = {8'h91 + 8'(2 * k), 8'h90 + 8'(2 * k)};
        u_host.wr(8'hD2, 8'hFF);
        chk("matrix", mtx, {c[0], c[1], c[2], c[1], c[3], c[4], c[2],
            c[4], c[5]});
        for (int i = 0; i < 12; i++)
            rdchk(8'hC6 + 8'(i), 8'h90 + 8'(i));
        rdchk(8'hD2, 8'h00);
    endtask
    task automatic t_remap();
        msi_vec3_t v;
        logic [2:0] s;
        logic [2:0] t;
        v = '{16'sh0123, -16'sh0456, 16'sh0789};
        for (int i = 0; i < 8; i++)
        begin
            s = 3'(i);
            t = 3'(7 - i);
            u_host.wr(8'hD4, {1'b0, s, 1'b0, t});
            u_host.wr(8'hD5, {5'h00, s});
            rdchk(8'hD4, {1'b0, s, 1'b0, t});
            rdchk(8'hD5, {5'h00, s});
            send(v);
            chk("sample", osmp, {pick(s, v), pick(s, v),
                pick(t, v)});
        end
    endtask
    task automatic summarize();
        if (error_cnt == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge i_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            error_cnt++;
            summarize();
        end
    end
    initial
    begin
        repeat (6) @(posedge i_clk);
        i_reset <= 1'b0;
        t_reset();
        t_coef();
        t_remap();
        summarize();
    end
endmodule

// ===== hw/msi_axis_remap.sv
// msi_axis_remap: picks one remapped axis out of a raw sample.
// assumes the sample and selector are stable on the same clock.
`timescale 1ns/1ps
module msi_axis_remap
(
    input wire msi_pkg::msi_vec3_t i_raw,
    input wire logic [2:0] i_sel,
    output logic signed [15:0] o_axis
);
    import msi_pkg::*;

    // negating the most negative code would wrap, so it saturates
    function automatic logic signed [15:0] msi_negate(
        input logic signed [15:0] v);
        logic signed [15:0] r;
        r = 16'sh7FFF;
        if (v != 16'sh8000)
        begin
            r = -v;
        end
        return r;
    endfunction

    always_comb
    begin
        unique case (i_sel)
            REMAP_POS_Y: o_axis = i_raw.y;
            REMAP_NEG_Y: o_axis = msi_negate(i_raw.y);
            REMAP_POS_X: o_axis = i_raw.x;
            REMAP_NEG_X: o_axis = msi_negate(i_raw.x);
            REMAP_NEG_Z: o_axis = msi_negate(i_raw.z);
            REMAP_POS_Z: o_axis = i_raw.z;
            // codes 110 and 111 fall back to plain y on every axis
            default: o_axis = i_raw.y;
        endcase
    end

endmodule

// ===== hw/msi_pkg.sv
// msi_pkg: constants, field layouts and carrier types for the
// magnetometer soft-iron and axis-remap register bank.
// assumes byte-wide register access at the printed offsets.
package msi_pkg;

    // register offsets
    localparam logic [7:0] OFF_SI_ROW1COL1_LOW = 8'hC6;
    localparam logic [7:0] OFF_SI_ROW1COL1_HIGH = 8'hC7;
    localparam logic [7:0] OFF_SI_ROW1COL2_LOW = 8'hC8;
    localparam logic [7:0] OFF_SI_ROW1COL2_HIGH = 8'hC9;
    localparam logic [7:0] OFF_SI_ROW1COL3_LOW = 8'hCA;
    localparam logic [7:0] OFF_SI_ROW1COL3_HIGH = 8'hCB;
    localparam logic [7:0] OFF_SI_ROW2COL2_LOW = 8'hCC;
    localparam logic [7:0] OFF_SI_ROW2COL2_HIGH = 8'hCD;
    localparam logic [7:0] OFF_SI_ROW2COL3_LOW = 8'hCE;
    localparam logic [7:0] OFF_SI_ROW2COL3_HIGH = 8'hCF;
    localparam logic [7:0] OFF_SI_ROW3COL3_LOW = 8'hD0;
    localparam logic [7:0] OFF_SI_ROW3COL3_HIGH = 8'hD1;
    localparam logic [7:0] OFF_AXIS_ROTATION_YZ = 8'hD4;
    localparam logic [7:0] OFF_AXIS_ROTATION_X = 8'hD5;

    // coefficient slots, in address order
    localparam int NUM_COEF = 6;
    localparam logic [2:0] SLOT_ROW1COL1 = 3'h0;
    localparam logic [2:0] SLOT_ROW1COL2 = 3'h1;
    localparam logic [2:0] SLOT_ROW1COL3 = 3'h2;
    localparam logic [2:0] SLOT_ROW2COL2 = 3'h3;
    localparam logic [2:0] SLOT_ROW2COL3 = 3'h4;
    localparam logic [2:0] SLOT_ROW3COL3 = 3'h5;

    // reset values
    localparam logic [7:0] RST_COEF_LOW = 8'h00;
    localparam logic [7:0] RST_ROW1COL1_HIGH = 8'h3C;
    localparam logic [7:0] RST_OFFDIAG_HIGH = 8'h00;
    localparam logic [7:0] RST_ROW2COL2_HIGH = 8'h3C;
    localparam logic [7:0] RST_ROW3COL3_HIGH = 8'h3C;
    localparam logic [2:0] RST_Y_REMAP_SEL = 3'h0;
    localparam logic [2:0] RST_Z_REMAP_SEL = 3'h5;
    localparam logic [2:0] RST_X_REMAP_SEL = 3'h2;

    // field positions in the rotation registers
    localparam int POS_Y_REMAP_SEL = 4;
    localparam int POS_Z_REMAP_SEL = 0;
    localparam int POS_X_REMAP_SEL = 0;

    // remap selector codes, shared by all three axes
    localparam logic [2:0] REMAP_POS_Y = 3'h0;
    localparam logic [2:0] REMAP_NEG_Y = 3'h1;
    localparam logic [2:0] REMAP_POS_X = 3'h2;
    localparam logic [2:0] REMAP_NEG_X = 3'h3;
    localparam logic [2:0] REMAP_NEG_Z = 3'h4;
    localparam logic [2:0] REMAP_POS_Z = 3'h5;

    // half-precision layout: sign, 5-bit exponent, 10-bit fraction
    typedef struct packed {
        logic sign;
        logic [4:0] exponent;
        logic [9:0] fraction;
    } msi_half_t;

    typedef struct packed {
        logic signed [15:0] x;
        logic signed [15:0] y;
        logic signed [15:0] z;
    } msi_vec3_t;

    // full 3x3 matrix, row-major
    typedef struct packed {
        msi_half_t r1c1;
        msi_half_t r1c2;
        msi_half_t r1c3;
        msi_half_t r2c1;
        msi_half_t r2c2;
        msi_half_t r2c3;
        msi_half_t r3c1;
        msi_half_t r3c2;
        msi_half_t r3c3;
    } msi_matrix_t;

    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } msi_reg_req_t;

endpackage

// ===== hw/msi_regs.sv
// msi_regs: soft-iron coefficient and axis-rotation register bank,
// with the remapped sample and expanded matrix it drives.
// assumes the page mechanism in front presents plain byte accesses
// on i_req, and that samples come from logic on the same clock.
`timescale 1ns/1ps

// How it works
// - a coefficient is a half float: sign, 5 exponent, 10 fraction bits.
// - a coefficient's low byte is at the lower address, high byte above.
// - one stored row1-col2 value feeds both row1-col2 and row2-col1.
// - one stored row1-col3 value feeds both row1-col3 and row3-col1.
// - one stored row2-col3 value feeds both row2-col3 and row3-col2.
// - row2-col2 resets to high byte 0x3C and low byte zero.
// - row3-col3 resets to high byte 0x3C and low byte zero.
// - off-diagonal bytes and the row1-col1 low byte reset to zero.
// - the first rotation register holds y select in 6:4, z select in 2:0.
// - y select picks y, -y, x, -x, -z, z, with other codes giving y.
// - z select picks y, -y, x, -x, -z, z, with other codes giving y.
// - the second rotation register holds x select in 2:0.
// - x select picks y, -y, x, -x, -z, z, with other codes giving y.
module msi_regs
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire msi_pkg::msi_reg_req_t i_req,
    output logic [7:0] o_rdata,
    output logic o_rvalid,
    input wire logic i_sample_valid,
    input wire msi_pkg::msi_vec3_t i_sample,
    output logic o_sample_valid,
    output msi_pkg::msi_vec3_t o_sample,
    output msi_pkg::msi_matrix_t o_softiron
);
    import msi_pkg::*;

    typedef struct packed {
        logic [NUM_COEF-1:0][7:0] coef_low;
        logic [NUM_COEF-1:0][7:0] coef_high;
        logic [2:0] y_remap_sel;
        logic [2:0] z_remap_sel;
        logic [2:0] x_remap_sel;
        logic [7:0] rdata;
        logic rvalid;
        logic sample_valid;
        msi_vec3_t sample;
    } msi_state_t;

    msi_state_t state;
    msi_state_t next_state;
    msi_vec3_t remapped;

    // true when the address falls in the coefficient window
    function automatic logic msi_is_coef(input logic [7:0] addr);
        return (addr >= OFF_SI_ROW1COL1_LOW) &&
               (addr <= OFF_SI_ROW3COL3_HIGH);
    endfunction

    // coefficient slot of an address inside the window
    function automatic logic [2:0] msi_slot(input logic [7:0] addr);
        logic [7:0] rel;
        rel = addr - OFF_SI_ROW1COL1_LOW;
        return rel[3:1];
    endfunction

    function automatic msi_half_t msi_coef(
        input msi_state_t s, input logic [2:0] slot);
        // odd offsets carry bits 15:8
        return {s.coef_high[slot], s.coef_low[slot]};
    endfunction

    msi_axis_remap u_remap_x
    (
        .i_raw(i_sample),
        .i_sel(state.x_remap_sel),
        .o_axis(remapped.x)
    );

    msi_axis_remap u_remap_y
    (
        .i_raw(i_sample),
        .i_sel(state.y_remap_sel),
        .o_axis(remapped.y)
    );

    msi_axis_remap u_remap_z
    (
        .i_raw(i_sample),
        .i_sel(state.z_remap_sel),
        .o_axis(remapped.z)
    );

    always_comb
    begin
        next_state = state;
        next_state.rvalid = i_req.rd_en;
        next_state.sample_valid = i_sample_valid;
        if (i_sample_valid)
        begin
            next_state.sample = remapped;
        end
        if (i_req.wr_en)
        begin
            if (msi_is_coef(i_req.addr))
            begin
                if (i_req.addr[0])
                begin
                    next_state.coef_high[msi_slot(i_req.addr)] =
                        i_req.wdata;
                end
                else
                begin
                    next_state.coef_low[msi_slot(i_req.addr)] =
                        i_req.wdata;
                end
            end
            else if (i_req.addr == OFF_AXIS_ROTATION_YZ)
            begin
                // reserved bits 7 and 3 are dropped
                next_state.y_remap_sel =
                    i_req.wdata[POS_Y_REMAP_SEL +: 3];
                next_state.z_remap_sel =
                    i_req.wdata[POS_Z_REMAP_SEL +: 3];
            end
            else if (i_req.addr == OFF_AXIS_ROTATION_X)
            begin
                next_state.x_remap_sel =
                    i_req.wdata[POS_X_REMAP_SEL +: 3];
            end
        end
        if (i_req.rd_en)
        begin
            next_state.rdata = 8'h00;
            if (msi_is_coef(i_req.addr))
            begin
                next_state.rdata = i_req.addr[0] ?
                    state.coef_high[msi_slot(i_req.addr)] :
                    state.coef_low[msi_slot(i_req.addr)];
            end
            else if (i_req.addr == OFF_AXIS_ROTATION_YZ)
            begin
                next_state.rdata[POS_Y_REMAP_SEL +: 3] =
                    state.y_remap_sel;
                next_state.rdata[POS_Z_REMAP_SEL +: 3] =
                    state.z_remap_sel;
            end
            else if (i_req.addr == OFF_AXIS_ROTATION_X)
            begin
                next_state.rdata[POS_X_REMAP_SEL +: 3] =
                    state.x_remap_sel;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            state <= '0;
            for (int i = 0; i < NUM_COEF; i++)
            begin
                state.coef_low[i] <= RST_COEF_LOW;
                state.coef_high[i] <= RST_OFFDIAG_HIGH;
            end
            state.coef_high[SLOT_ROW1COL1] <= RST_ROW1COL1_HIGH;
            state.coef_high[SLOT_ROW2COL2] <= RST_ROW2COL2_HIGH;
            state.coef_high[SLOT_ROW3COL3] <= RST_ROW3COL3_HIGH;
            state.y_remap_sel <= RST_Y_REMAP_SEL;
            state.z_remap_sel <= RST_Z_REMAP_SEL;
            state.x_remap_sel <= RST_X_REMAP_SEL;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign o_rdata = state.rdata;
    assign o_rvalid = state.rvalid;
    assign o_sample_valid = state.sample_valid;
    assign o_sample = state.sample;

    always_comb
    begin
        o_softiron.r1c1 = msi_coef(state, SLOT_ROW1COL1);
        o_softiron.r1c2 = msi_coef(state, SLOT_ROW1COL2);
        o_softiron.r2c1 = msi_coef(state, SLOT_ROW1COL2);
        o_softiron.r1c3 = msi_coef(state, SLOT_ROW1COL3);
        o_softiron.r3c1 = msi_coef(state, SLOT_ROW1COL3);
        o_softiron.r2c2 = msi_coef(state, SLOT_ROW2COL2);
        o_softiron.r2c3 = msi_coef(state, SLOT_ROW2COL3);
        o_softiron.r3c2 = msi_coef(state, SLOT_ROW2COL3);
        o_softiron.r3c3 = msi_coef(state, SLOT_ROW3COL3);
    end

endmodule
